/* inc/iodc_pkg.sv */
// Package with the map, field layout and timing of the interrupt pin block.
// Operation
// - Interval field 31:24, read/write, reset zero, in 10 us steps.
// - Zero interval write stops gating, clears counter, frees pending.
// - A new non-zero interval applies to every later interrupt.
// - Power event source is never held off by a running interval.
// - Writing one to bit 14 with a non-zero interval clears counter and starts a fresh interval.
// - Bit 13 flags a running interval; enabled interrupts other than the power event are blocked.
// - Bit 12 mirrors the internal line, whatever pin enable or interval.
// - Pin enable bit 8 clear keeps the pin deasserted; status unaffected.
// - Polarity bit 4 selects low or high active pin, push-pull only.
// - Bit 0 selects open-drain when zero, push-pull when one.
// - Source status bits are cleared by software writing one to them.
`default_nettype none
package iodc_pkg;
  // Register byte offsets on the host bus.
  localparam logic [7:0] OFS_PIN_CFG    = 8'h54;
  localparam logic [7:0] OFS_SRC_STATUS = 8'h58;
  localparam logic [7:0] OFS_SRC_ENABLE = 8'h5C;
  // Field positions inside the configuration register.
  localparam int INTERVAL_LSB = 24;
  localparam int INTERVAL_W   = 8;
  localparam int RESTART_BIT  = 14;
  localparam int ACTIVE_BIT   = 13;
  localparam int PENDING_BIT  = 12;
  localparam int PIN_EN_BIT   = 8;
  localparam int POLARITY_BIT = 4;
  localparam int BUF_TYPE_BIT = 0;
  // Reset values.
  localparam logic [7:0]  RST_INTERVAL = 8'h00;
  localparam logic        RST_PIN_EN   = 1'b0;
  localparam logic        RST_POLARITY = 1'b0;
  localparam logic        RST_BUF_TYPE = 1'b0;
  localparam logic [31:0] RST_STATUS   = 32'h00000000;
  localparam logic [31:0] RST_ENABLE   = 32'h00000000;
  // Interval step and the clock it is counted on.
  localparam int STEP_NS      = 10000;
  localparam int CLK_NS       = 50;
  localparam int STEP_CYCLES  = (STEP_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

/* verilog/iodc_tick.sv */
// Divider that makes the one-cycle interval step enable.
`timescale 1ns/1ps
`default_nettype none
module iodc_tick #(
  parameter int CYCLES = iodc_pkg::STEP_CYCLES
) (
  input  wire logic clk_sys, // System clock.
  input  wire logic reset,   // Asynchronous reset, active high.
  input  wire logic restart, // Realigns the step to an interval start.
  output logic      tick_q   // One-cycle pulse per step.
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;

  // A step shorter than two clocks cannot be told apart from a restart.
  if (CYCLES < 2) begin : g_cycles_check
    $error("iodc_tick needs at least two cycles per step");
  end

  // Restart realigns the phase so an interval always lasts whole steps.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (restart) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verilog/iodc_ctrl.sv */
// Interrupt pin controller with deassertion interval timer.
`timescale 1ns/1ps
`default_nettype none
module iodc_ctrl #(
  parameter int NUM_SRC = 8,           // Number of interrupt sources.
  parameter int PWR_IDX = 0,           // Index of the power event source.
  parameter int STEP    = iodc_pkg::STEP_CYCLES // Clocks per 10 us step.
) (
  input  wire logic               clk_sys,      // System clock.
  input  wire logic               reset,        // Async reset, high.
  input  wire logic [7:0]         host_addr,    // Register byte address.
  input  wire logic [31:0]        host_wdata,   // Write data.
  input  wire logic               host_wr,      // Write strobe, one cycle.
  input  wire logic               host_rd,      // Read strobe, one cycle.
  output logic      [31:0]        host_rdata_q, // Read data, next cycle.
  input  wire logic [NUM_SRC-1:0] src_event,    // Source event pulses.
  output logic                    irq_out_q,    // Pin output level.
  output logic                    irq_oe_q      // Pin output enable.
);
  // Parameters that the logic cannot serve stop the build.
  if (NUM_SRC < 1 || NUM_SRC > 32) begin : g_num_check
    $error("iodc_ctrl supports 1 to 32 sources");
  end
  if (PWR_IDX < 0 || PWR_IDX >= NUM_SRC) begin : g_pwr_check
    $error("iodc_ctrl power event index out of range");
  end

  localparam int LSB = iodc_pkg::INTERVAL_LSB;
  localparam int W   = iodc_pkg::INTERVAL_W;

  logic [W-1:0]       deas_q;
  logic               pin_en_q;
  logic               pol_q;
  logic               type_q;
  logic [NUM_SRC-1:0] status_q;
  logic [NUM_SRC-1:0] enable_q;
  logic               active_q;
  logic [W-1:0]       cnt_q;
  logic               asserted_q;
  logic               tick;

  // Decoded write strobes.
  logic wr_cfg;
  logic wr_sts;
  logic wr_en;
  assign wr_cfg = host_wr && (host_addr == iodc_pkg::OFS_PIN_CFG);
  assign wr_sts = host_wr && (host_addr == iodc_pkg::OFS_SRC_STATUS);
  assign wr_en  = host_wr && (host_addr == iodc_pkg::OFS_SRC_ENABLE);

  // Fields of the incoming configuration write.
  logic [W-1:0] wr_deas;
  logic         wr_restart;
  assign wr_deas    = host_wdata[LSB +: W];
  assign wr_restart = host_wdata[iodc_pkg::RESTART_BIT];

  // Internal line and the power event that bypasses the interval.
  logic master;
  logic pwr_pend;
  assign master   = |(status_q & enable_q);
  assign pwr_pend = status_q[PWR_IDX] && enable_q[PWR_IDX];

  // Pin request: gated sources only outside an interval.
  logic asserted_d;
  assign asserted_d = pin_en_q &&
                      ((master && !active_q) || pwr_pend);

  // Interval start events and the effective length.
  logic         zero_wr;
  logic [W-1:0] deas_nxt;
  logic         restart_go;
  logic         release_go;
  logic         start;
  logic         expired;
  assign zero_wr    = wr_cfg && (wr_deas == '0);
  assign deas_nxt   = wr_cfg ? wr_deas : deas_q;
  assign restart_go = wr_cfg && wr_restart && (wr_deas != '0);
  assign release_go = asserted_q && !asserted_d && (deas_nxt != '0);
  assign start      = !zero_wr && (restart_go || release_go);
  // The live field is compared, so a rewrite shortens or lengthens at once.
  assign expired    = (cnt_q >= deas_q) ||
                      (tick && (cnt_q + 1'b1 >= deas_q));

  iodc_tick #(
    .CYCLES (STEP)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (start),
    .tick_q  (tick)
  );

  // Configuration fields; reserved bits are simply not stored.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      deas_q   <= iodc_pkg::RST_INTERVAL;
      pin_en_q <= iodc_pkg::RST_PIN_EN;
      pol_q    <= iodc_pkg::RST_POLARITY;
      type_q   <= iodc_pkg::RST_BUF_TYPE;
    end else if (wr_cfg) begin
      deas_q   <= wr_deas;
      pin_en_q <= host_wdata[iodc_pkg::PIN_EN_BIT];
      pol_q    <= host_wdata[iodc_pkg::POLARITY_BIT];
      type_q   <= host_wdata[iodc_pkg::BUF_TYPE_BIT];
    end
  end

  // Sticky source status; a new event wins over a same-cycle clear.
  logic [NUM_SRC-1:0] clr_mask;
  assign clr_mask = wr_sts ? host_wdata[NUM_SRC-1:0] : '0;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_q <= iodc_pkg::RST_STATUS[NUM_SRC-1:0];
    end else begin
      status_q <= (status_q & ~clr_mask) | src_event;
    end
  end

  // Source enables.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enable_q <= iodc_pkg::RST_ENABLE[NUM_SRC-1:0];
    end else if (wr_en) begin
      enable_q <= host_wdata[NUM_SRC-1:0];
    end
  end

  // Interval timer; a zero write takes priority over any start.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else if (zero_wr) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else if (start) begin
      active_q <= 1'b1;
      cnt_q    <= '0;
    end else if (active_q && expired) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else if (active_q && tick) begin
      cnt_q    <= cnt_q + 1'b1;
    end
  end

  // Pin driver. Open-drain only pulls low; push-pull honours polarity.
  // With the pin disabled, push-pull still drives the idle level so the
  // host input never floats.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      asserted_q <= 1'b0;
      irq_out_q  <= 1'b0;
      irq_oe_q   <= 1'b0;
    end else begin
      asserted_q <= asserted_d;
      if (type_q) begin
        irq_out_q <= pol_q ? asserted_d : !asserted_d;
        irq_oe_q  <= 1'b1;
      end else begin
        irq_out_q <= 1'b0;
        irq_oe_q  <= asserted_d;
      end
    end
  end

  // Read mux; restart bit and reserved bits read zero.
  logic [31:0] rd_cfg;
  logic [31:0] rd_sts;
  logic [31:0] rd_en;
  always_comb begin
    rd_cfg = '0;
    rd_cfg[LSB +: W]                 = deas_q;
    rd_cfg[iodc_pkg::ACTIVE_BIT]     = active_q;
    rd_cfg[iodc_pkg::PENDING_BIT]    = master;
    rd_cfg[iodc_pkg::PIN_EN_BIT]     = pin_en_q;
    rd_cfg[iodc_pkg::POLARITY_BIT]   = pol_q;
    rd_cfg[iodc_pkg::BUF_TYPE_BIT]   = type_q;
    rd_sts = '0;
    rd_sts[NUM_SRC-1:0] = status_q;
    rd_en = '0;
    rd_en[NUM_SRC-1:0] = enable_q;
  end

  // Unmapped reads return zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      host_rdata_q <= '0;
    end else if (host_rd) begin
      case (host_addr)
        iodc_pkg::OFS_PIN_CFG:    host_rdata_q <= rd_cfg;
        iodc_pkg::OFS_SRC_STATUS: host_rdata_q <= rd_sts;
        iodc_pkg::OFS_SRC_ENABLE: host_rdata_q <= rd_en;
        default:                  host_rdata_q <= '0;
      endcase
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cfg_rd;
    host_rd && (host_addr == iodc_pkg::OFS_PIN_CFG);
  endsequence

  sequence s_restart;
    wr_cfg && wr_restart && (wr_deas != '0);
  endsequence

  a_cfg_readback: assert property (
    s_cfg_rd |=> host_rdata_q[LSB +: W] == $past(deas_q))
    else $error("interval field read back wrong");

  a_zero_clears: assert property (
    zero_wr |=> !active_q && cnt_q == '0)
    else $error("zero interval did not stop the timer");

  a_new_length: assert property (
    active_q && !wr_cfg && !release_go && cnt_q >= deas_q |=> !active_q)
    else $error("interval outlived its length");

  a_pwr_bypass: assert property (
    pwr_pend && pin_en_q && active_q |=> asserted_q)
    else $error("power event held off by interval");

  // A zero write in the very next cycle may end the interval at once.
  a_restart_run: assert property (
    s_restart ##1 !zero_wr |-> active_q && cnt_q == '0 ##1 active_q)
    else $error("restart did not begin an interval");

  a_active_blocks: assert property (
    active_q && !pwr_pend |=> !asserted_q)
    else $error("interrupt reached pin during interval");

  a_pending_read: assert property (
    s_cfg_rd |=> host_rdata_q[iodc_pkg::PENDING_BIT] == $past(master))
    else $error("pending bit does not mirror internal line");

  a_pin_disabled: assert property (
    !pin_en_q && !type_q |=> !irq_oe_q && !asserted_q)
    else $error("disabled open-drain pin is driven");

  a_push_pull: assert property (
    type_q && pin_en_q |=>
      irq_oe_q && (irq_out_q == ($past(pol_q) ~^ asserted_q)))
    else $error("push-pull level does not follow polarity");

  a_open_drain: assert property (
    !type_q |=> !irq_out_q && (irq_oe_q == asserted_q))
    else $error("open-drain pin drove high");

  a_status_w1c: assert property (
    wr_sts |=> (status_q & $past(clr_mask) & ~$past(src_event)) == '0)
    else $error("status bit not cleared by write of one");

  a_release_start: assert property (
    (release_go && !wr_cfg) ##1 !zero_wr |-> active_q [*2])
    else $error("pin release did not start an interval");

  a_reserved_zero: assert property (
    s_cfg_rd |=> host_rdata_q[23:15] == '0 && host_rdata_q[11:9] == '0 &&
                 host_rdata_q[7:5] == '0 && host_rdata_q[3:1] == '0)
    else $error("reserved configuration bits not zero");

  // A zero write followed by a pending line must reach the pin next.
  sequence s_zero_then_pending;
    zero_wr ##1 (pin_en_q && master);
  endsequence

  a_zero_issues: assert property (
    s_zero_then_pending |=> asserted_q)
    else $error("pending interrupt not issued after zero interval");

  a_count_bound: assert property (
    active_q && !$past(wr_cfg) |-> cnt_q < deas_q)
    else $error("interval count ran past its length");

  a_restart_rd_zero: assert property (
    s_cfg_rd |=> !host_rdata_q[iodc_pkg::RESTART_BIT])
    else $error("restart bit did not read zero");

  a_active_read: assert property (
    s_cfg_rd |=> host_rdata_q[iodc_pkg::ACTIVE_BIT] == $past(active_q))
    else $error("interval flag read back wrong");

  a_enabled_passes: assert property (
    pin_en_q && master && !active_q |=> asserted_q)
    else $error("enabled interrupt held off outside interval");

  a_disabled_idle: assert property (
    !pin_en_q |=> !asserted_q)
    else $error("disabled pin still requested");

  a_event_sets: assert property (
    (|src_event) |=> (status_q & $past(src_event)) == $past(src_event))
    else $error("source event lost against a clear");

  a_tick_realign: assert property (
    start |=> !tick)
    else $error("step divider not realigned at interval start");
endmodule
`default_nettype wire

/* verif/iodc_host_model.sv */
// Host side model of the interrupt wire seen by the processor input.
`timescale 1ns/1ps
`default_nettype none
module iodc_host_model (
  input  wire logic irq_out_q, // Pin level from the block.
  input  wire logic irq_oe_q,  // Pin drive enable from the block.
  output logic      pin_wire   // Level at the processor input.
);
  // A board pull-up holds the wire high while nobody drives it.
  assign pin_wire = irq_oe_q ? irq_out_q : 1'b1;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking testbench for the interrupt pin controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int         STEP = 4;
  localparam logic [7:0] CFG  = iodc_pkg::OFS_PIN_CFG;
  localparam logic [7:0] STS  = iodc_pkg::OFS_SRC_STATUS;
  localparam logic [7:0] ENA  = iodc_pkg::OFS_SRC_ENABLE;
  logic        clk_sys    = 1'b0;
  logic        reset      = 1'b1;
  logic [7:0]  host_addr  = 8'h00;
  logic [31:0] host_wdata = 32'h00000000;
  logic        host_wr    = 1'b0;
  logic        host_rd    = 1'b0;
  logic [7:0]  src_event  = 8'h00;
  logic [31:0] host_rdata_q;
  logic        irq_out_q;
  logic        irq_oe_q;
  logic        pin_wire;
  int          error_cnt   = 0;
  int          check_count = 0;

  // A short step keeps each interval to a few dozen cycles.
  iodc_ctrl #(.STEP(STEP)) uut (
    .clk_sys(clk_sys), .reset(reset), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata_q(host_rdata_q), .src_event(src_event),
    .irq_out_q(irq_out_q), .irq_oe_q(irq_oe_q));
  iodc_host_model host (
    .irq_out_q(irq_out_q), .irq_oe_q(irq_oe_q), .pin_wire(pin_wire));

  // The clock runs at 20 MHz.
  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bus tasks hold every strobe until the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk_sys);
    host_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge clk_sys);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk_sys);
    host_rd <= 1'b0;
    cyc(1);
    chk(nm, host_rdata_q, e);
  endtask
  task automatic ev(input logic [7:0] m);
    @(posedge clk_sys);
    src_event <= m;
    @(posedge clk_sys);
    src_event <= 8'h00;
  endtask
  task automatic pin(input logic e);
    chk("pin", {31'h0, pin_wire}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd(CFG, 32'h00000000, "cfg_reset");
    chk("oe_reset", {31'h0, irq_oe_q}, 32'h0);
    wr(CFG, 32'h00FF8EEE);
    rd(CFG, 32'h00000000, "cfg_rsvd");
    rd(8'h60, 32'h00000000, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_basic;
    wr(CFG, 32'h00000111);
    wr(ENA, 32'h00000003);
    ev(8'h02);
    cyc(3);
    pin(1'b1);
    rd(CFG, 32'h00001111, "pending");
    wr(STS, 32'h00000002);
    cyc(3);
    pin(1'b0);
    rd(CFG, 32'h00000111, "no_interval");
    $display("test basic done");
  endtask
  // The power event is let through while an interval runs.
  task automatic t_interval;
    wr(CFG, 32'h03000111);
    ev(8'h02);
    cyc(3);
    wr(STS, 32'h00000002);
    ev(8'h01);
    cyc(3);
    pin(1'b1);
    wr(STS, 32'h00000001);
    ev(8'h02);
    cyc(2);
    pin(1'b0);
    rd(CFG, 32'h03003111, "gated");
    cyc(20);
    pin(1'b1);
    $display("test interval done");
  endtask
  task automatic t_restart;
    wr(STS, 32'h00000002);
    ev(8'h02);
    cyc(5);
    wr(CFG, 32'h03004111);
    cyc(9);
    pin(1'b0);
    cyc(12);
    pin(1'b1);
    rd(CFG, 32'h03001111, "restart_rd");
    $display("test restart done");
  endtask
  task automatic t_zero;
    wr(CFG, 32'hFF000111);
    wr(STS, 32'h00000002);
    ev(8'h02);
    cyc(3);
    pin(1'b0);
    wr(CFG, 32'h00000111);
    cyc(3);
    pin(1'b1);
    rd(CFG, 32'h00001111, "deas_off");
    // A long interval cut short by a lower value ends at once.
    wr(CFG, 32'hFF000111);
    wr(STS, 32'h00000002);
    ev(8'h02);
    cyc(3);
    pin(1'b0);
    wr(CFG, 32'h01000111);
    cyc(8);
    pin(1'b1);
    rd(CFG, 32'h01001111, "deas_low");
    $display("test zero done");
  endtask
  // The source stays pending while the output modes are walked.
  task automatic t_modes;
    wr(CFG, 32'h00000011);
    cyc(3);
    pin(1'b0);
    rd(CFG, 32'h00001011, "en_off");
    wr(CFG, 32'h00000101);
    cyc(3);
    pin(1'b0);
    chk("oe_pp", {31'h0, irq_oe_q}, 32'h1);
    wr(CFG, 32'h00000110);
    cyc(3);
    pin(1'b0);
    wr(STS, 32'h00000002);
    cyc(3);
    pin(1'b1);
    chk("oe_od", {31'h0, irq_oe_q}, 32'h0);
    $display("test modes done");
  endtask

  // Main sequence after 20 cycles of reset.
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_basic;
    t_interval;
    t_restart;
    t_zero;
    t_modes;
    report_and_stop;
  end
  // The tests need some 190 cycles, so 5000 marks a hang.
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
